// File: core/bchan_regs.sv
// Host register block with receive and transmit queues of one B channel.
`timescale 1ns/1ps
module bchan_regs
  import hdlc_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic SRST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic [7:0] RX_DATA_I,
  input wire logic RX_VALID_I,
  input wire logic RX_END_I,
  input wire logic RX_CRC_ERR_I,
  input wire logic RX_ABORT_I,
  output logic RX_READY_O,
  output logic [7:0] TX_DATA_O,
  output logic TX_VALID_O,
  input wire logic TX_READY_I,
  input wire logic TX_BUSY_I,
  input wire logic TX_UNDERRUN_I,
  output logic TX_START_O,
  output logic TX_END_O,
  output logic TX_RESET_O,
  output logic RX_RESET_O,
  output logic [7:0] MODE_O,
  output logic [7:0] IDLE_O,
  output logic [7:0] ADDR_MASK1_O,
  output logic [7:0] ADDR_MASK2_O,
  output logic [7:0] ADDR_CMP1_O,
  output logic [7:0] ADDR_CMP2_O
);
  // ********************************************
  // State
  // ********************************************
  typedef struct packed {
    logic [7:0] rdata;
    logic [7:0] mode;
    logic [7:0] mask;
    logic [7:0] flags;
    logic [7:0] adm1;
    logic [7:0] adm2;
    logic [7:0] adr1;
    logic [7:0] adr2;
    logic [7:0] idle;
    logic [12:0] fcnt;
    logic [12:0] bcnt;
    logic lov_run;
    logic length_overflow_flag;
    logic ovf;
    logic crc;
    logic abt;
    logic tx_overwrite_flag;
    logic rx_armed;
    logic tx_armed;
    logic [7:0] txd;
    logic txv;
    logic start;
    logic endp;
    logic txrst;
    logic rxrst;
    logic rxrdy;
  } st_t;
  st_t s_reg;
  st_t s_next;
  queue_if rxq ();
  queue_if txq ();
  logic [7:0] cmd;
  logic [7:0] thr;
  logic [7:0] tx_free;
  logic [7:0] ev;
  logic rx_end_ok;

  // Address decode shared by reads, writes and the queue ports
  function automatic logic sel(input logic [7:0] a,
                               input logic [7:0] o);
    sel = (a == o);
  endfunction

  // ********************************************
  // Queues
  // ********************************************
  byte_queue #(.W(QW), .D(QD)) u_rxq (
    .clk_i(SYS_CLK_I),
    .srst_i(SRST_I),
    .q(rxq.store)
  );
  byte_queue #(.W(QW), .D(QD)) u_txq (
    .clk_i(SYS_CLK_I),
    .srst_i(SRST_I),
    .q(txq.store)
  );

  // Command bits exist only in the write cycle, so they self-clear
  assign cmd = (WR_I && sel(ADDR_I, OFF_CMD)) ? WDATA_I : 8'h00;
  assign thr = thr_of(s_reg.mode);
  assign tx_free = QD_B - txq.cnt;

  // Queue hookup: host ports and the line side
  assign rxq.wdata = RX_DATA_I;
  assign rxq.wvalid = RX_VALID_I;
  assign rxq.rready = RD_I && sel(ADDR_I, OFF_RXQ);
  assign rxq.clr = cmd[CMD_RX_RESET_CMD];
  assign txq.wdata = WDATA_I;
  assign txq.wvalid = WR_I && sel(ADDR_I, OFF_TXQ);
  assign txq.rready = !s_reg.txv || TX_READY_I;
  assign txq.clr = cmd[CMD_TX_RESET_CMD];

  // Frame end counts only in transparent mode
  assign rx_end_ok = RX_VALID_I && RX_END_I && !s_reg.mode[MODE_MMS];

  // ********************************************
  // Event sources
  // ********************************************
  // One ready event per threshold crossing; receive re-armed by acknowledge, transmit once free space drops below threshold
  always_comb begin
    ev = 8'h00;
    ev[EV_RMR] = s_reg.rx_armed && (rxq.cnt > thr);
    ev[EV_RME] = rx_end_ok;
    ev[EV_OVF] = RX_VALID_I && !rxq.wready;
    ev[EV_XFR] = s_reg.tx_armed && (tx_free >= thr);
    ev[EV_UND] = TX_UNDERRUN_I;
  end

  // ********************************************
  // Next state
  // ********************************************
  always_comb begin
    s_next = s_reg;
    s_next.start = cmd[CMD_XMS];
    s_next.endp = cmd[CMD_XME];
    s_next.txrst = cmd[CMD_TX_RESET_CMD];
    s_next.rxrst = cmd[CMD_RX_RESET_CMD];
    // One spare slot covers the push already in flight
    s_next.rxrdy = (rxq.cnt < (QD_B - 8'h01));
    // Register writes
    if (WR_I) begin
      case (1'b1)
        sel(ADDR_I, OFF_MODE): s_next.mode = WDATA_I;
        sel(ADDR_I, OFF_MASK):
          s_next.mask = WDATA_I | MASK_FIXED;
        sel(ADDR_I, OFF_ADM1): s_next.adm1 = WDATA_I;
        sel(ADDR_I, OFF_ADM2): s_next.adm2 = WDATA_I;
        sel(ADDR_I, OFF_ADR1): s_next.adr1 = WDATA_I;
        sel(ADDR_I, OFF_ADR2): s_next.adr2 = WDATA_I;
        sel(ADDR_I, OFF_IDLE): s_next.idle = WDATA_I;
        default: s_next.mode = s_reg.mode;
      endcase
    end
    // A full transmit queue drops the byte and remembers it
    if (txq.wvalid && !txq.wready) begin
      s_next.tx_overwrite_flag = 1'b1;
    end
    // Transmit output stage refills whenever it empties
    if (s_reg.txv && TX_READY_I) begin
      s_next.txv = 1'b0;
    end
    if (txq.rvalid && txq.rready) begin
      s_next.txd = txq.rdata;
      s_next.txv = 1'b1;
    end
    // Frame byte counter, 13 bits with sticky wrap
    if (RX_VALID_I) begin
      s_next.fcnt = s_reg.fcnt + 13'h0001;
      if (s_reg.fcnt == 13'h1FFF) begin
        s_next.lov_run = 1'b1;
      end
    end
    if (rx_end_ok) begin
      s_next.bcnt = s_reg.fcnt + 13'h0001;
      s_next.length_overflow_flag = s_reg.lov_run || (s_reg.fcnt == 13'h1FFF);
      s_next.crc = RX_CRC_ERR_I;
      s_next.fcnt = 13'h0000;
      s_next.lov_run = 1'b0;
    end
    // Ready events fire once, then wait to be re-armed
    if (ev[EV_RMR]) begin
      s_next.rx_armed = 1'b0;
    end
    if (cmd[CMD_ACK]) begin
      s_next.rx_armed = 1'b1;
    end
    if (ev[EV_XFR]) begin
      s_next.tx_armed = 1'b0;
    end else if (tx_free < thr) begin
      s_next.tx_armed = 1'b1;
    end
    // Receiver reset wipes overflow and abort status, the frame counter and the queue
    if (cmd[CMD_RX_RESET_CMD]) begin
      s_next.ovf = 1'b0;
      s_next.abt = 1'b0;
      s_next.fcnt = 13'h0000;
      s_next.lov_run = 1'b0;
      s_next.rx_armed = 1'b1;
    end
    // Transmitter reset ends in a ready condition
    if (cmd[CMD_TX_RESET_CMD]) begin
      s_next.tx_overwrite_flag = 1'b0;
      s_next.txv = 1'b0;
      s_next.tx_armed = 1'b1;
    end
    // Overflow and abort sets come after the resets so a same-cycle event survives
    if (ev[EV_OVF]) begin
      s_next.ovf = 1'b1;
    end
    if (RX_ABORT_I) begin
      s_next.abt = 1'b1;
    end
    // Read-clear keeps masked flags pending; new events still win
    if (RD_I && sel(ADDR_I, OFF_EVT)) begin
      s_next.flags = s_reg.flags & s_reg.mask;
    end
    s_next.flags = s_next.flags | ev;
    // Read data is captured in the read cycle
    if (RD_I) begin
      case (1'b1)
        sel(ADDR_I, OFF_RXQ):
          s_next.rdata = rxq.rvalid ? rxq.rdata : 8'h00;
        sel(ADDR_I, OFF_MODE): s_next.rdata = s_reg.mode;
        sel(ADDR_I, OFF_EVT):
          s_next.rdata = s_reg.flags & ~s_reg.mask;
        sel(ADDR_I, OFF_MASK): s_next.rdata = s_reg.mask;
        sel(ADDR_I, OFF_STAT):
          s_next.rdata = {1'b0, s_reg.ovf, s_reg.crc, s_reg.abt,
                          1'b0, s_reg.tx_overwrite_flag, 1'b0, TX_BUSY_I};
        sel(ADDR_I, OFF_ADM1): s_next.rdata = s_reg.adm1;
        sel(ADDR_I, OFF_ADM2): s_next.rdata = s_reg.adm2;
        sel(ADDR_I, OFF_ADR1): s_next.rdata = s_reg.adr1;
        sel(ADDR_I, OFF_ADR2): s_next.rdata = s_reg.adr2;
        sel(ADDR_I, OFF_CNTL): s_next.rdata = s_reg.bcnt[7:0];
        sel(ADDR_I, OFF_CNTH):
          s_next.rdata = {2'h0, s_reg.length_overflow_flag, s_reg.bcnt[12:8]};
        sel(ADDR_I, OFF_IDLE): s_next.rdata = s_reg.idle;
        // Command, transmit port and reserved slots read zero
        default: s_next.rdata = 8'h00;
      endcase
    end
  end

  // ********************************************
  // Registers
  // ********************************************
  // Only the event mask, check error and the two ready arms leave reset at one
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      s_reg <= '0;
      s_reg.mode <= RST_MODE;
      s_reg.mask <= RST_MASK;
      s_reg.crc <= RST_CRC;
      s_reg.rx_armed <= 1'b1;
      s_reg.tx_armed <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign RDATA_O = s_reg.rdata;
  assign RX_READY_O = s_reg.rxrdy;
  assign TX_DATA_O = s_reg.txd;
  assign TX_VALID_O = s_reg.txv;
  assign TX_START_O = s_reg.start;
  assign TX_END_O = s_reg.endp;
  assign TX_RESET_O = s_reg.txrst;
  assign RX_RESET_O = s_reg.rxrst;
  assign MODE_O = s_reg.mode;
  assign IDLE_O = s_reg.idle;
  assign ADDR_MASK1_O = s_reg.adm1;
  assign ADDR_MASK2_O = s_reg.adm2;
  assign ADDR_CMP1_O = s_reg.adr1;
  assign ADDR_CMP2_O = s_reg.adr2;

  // ********************************************
  // Checks
  // ********************************************
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SRST_I);

  cmd_self_clear_a: assert property (
    cmd[CMD_XMS] |=> TX_START_O ##1 !TX_START_O
  ) else $error("start command did not pulse once");
  rx_reset_pulse_a: assert property (
    cmd[CMD_RX_RESET_CMD] |=> RX_RESET_O && rxq.cnt == 8'h00 ##1 !RX_RESET_O
  ) else $error("receiver reset did not act");
  cmd_reads_zero_a: assert property (
    RD_I && sel(ADDR_I, OFF_CMD) |=> RDATA_O == 8'h00
  ) else $error("command register read not zero");
  mask_fixed_ones_a: assert property (
    (s_reg.mask & MASK_FIXED) == MASK_FIXED
  ) else $error("fixed mask bits lost");
  event_masked_read_a: assert property (
    RD_I && sel(ADDR_I, OFF_EVT) |=>
      (RDATA_O & $past(s_reg.mask)) == 8'h00
      && (s_reg.flags & $past(s_reg.mask))
         == (($past(s_reg.flags) | $past(ev)) & $past(s_reg.mask))
  ) else $error("masked flag shown or dropped");
  rx_ready_thresh_a: assert property (
    s_reg.rx_armed && rxq.cnt > thr |=>
      s_reg.flags[EV_RMR] && !s_reg.rx_armed
  ) else $error("receive ready missed");
  tx_ready_thresh_a: assert property (
    s_reg.tx_armed && tx_free >= thr |=> s_reg.flags[EV_XFR]
  ) else $error("transmit ready missed");
  overflow_flags_a: assert property (
    RX_VALID_I && !rxq.wready && !cmd[CMD_RX_RESET_CMD] |=>
      s_reg.ovf && s_reg.flags[EV_OVF]
  ) else $error("overflow not flagged");
  frame_end_mode_a: assert property (
    RX_VALID_I && RX_END_I && s_reg.mode[MODE_MMS]
      && !s_reg.flags[EV_RME] |=> !s_reg.flags[EV_RME]
  ) else $error("frame end in extended mode");
  rx_pop_one_a: assert property (
    rxq.rready && rxq.rvalid && !RX_VALID_I && !rxq.clr |=>
      rxq.cnt == $past(rxq.cnt) - 8'h01
  ) else $error("port read did not pop one");
  queue_depth_a: assert property (
    rxq.cnt <= QD_B && txq.cnt <= QD_B
  ) else $error("queue count beyond depth");
  thr_select_a: assert property (
    s_reg.mode[1:0] == FTS_HI |-> thr == THR_HI
  ) else $error("threshold select wrong");

  rx_full_c: cover property (rxq.cnt == QD_B);
  rx_end_c: cover property (rx_end_ok ##[1:100] cmd[CMD_ACK]);
  tx_drain_c: cover property (TX_VALID_O && !TX_READY_I [*3]);
  hi_thr_c: cover property (ev[EV_RMR] && thr == THR_HI);
endmodule // bchan_regs

// File: core/byte_queue.sv
// Parameterised first-in first-out byte store.
`timescale 1ns/1ps
module byte_queue
  import hdlc_pkg::*;
#(
  parameter int W = QW,
  parameter int D = QD
) (
  input wire logic clk_i,
  input wire logic srst_i,
  queue_if.store q
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] n;
  } st_t;
  st_t s_reg;
  st_t s_next;
  logic push;
  logic pop;

  // Flags come from the count so full and empty are exact
  assign q.wready = (s_reg.n != (AW+1)'(D));
  assign q.rvalid = (s_reg.n != '0);
  assign q.rdata = 8'(s_reg.mem[s_reg.rp]);
  assign q.cnt = 8'(s_reg.n);
  assign push = q.wvalid && q.wready;
  assign pop = q.rvalid && q.rready;

  // Clear beats push and pop in the same cycle
  always_comb begin
    s_next = s_reg;
    if (q.clr) begin
      s_next.wp = '0;
      s_next.rp = '0;
      s_next.n = '0;
    end else begin
      if (push) begin
        s_next.mem[s_reg.wp] = W'(q.wdata);
        s_next.wp = s_reg.wp + AW'(1);
      end
      if (pop) begin
        s_next.rp = s_reg.rp + AW'(1);
      end
      if (push && !pop) begin
        s_next.n = s_reg.n + (AW+1)'(1);
      end else if (pop && !push) begin
        s_next.n = s_reg.n - (AW+1)'(1);
      end
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule // byte_queue

// File: include/hdlc_pkg.sv
// Constants shared by the B-channel HDLC host queue controller.
package hdlc_pkg;
  // ********************************************
  // Queue geometry
  // ********************************************
  localparam int QW = 8;
  localparam int QD = 128;
  localparam logic [7:0] QD_B = 8'h80;
  // ********************************************
  // Register offsets
  // ********************************************
  localparam logic [7:0] OFF_RXQ = 8'h50;
  localparam logic [7:0] OFF_TXQ = 8'h51;
  localparam logic [7:0] OFF_CMD = 8'h53;
  localparam logic [7:0] OFF_MODE = 8'h54;
  localparam logic [7:0] OFF_EVT = 8'h56;
  localparam logic [7:0] OFF_MASK = 8'h57;
  localparam logic [7:0] OFF_STAT = 8'h58;
  localparam logic [7:0] OFF_ADM1 = 8'h59;
  localparam logic [7:0] OFF_ADM2 = 8'h5A;
  localparam logic [7:0] OFF_ADR1 = 8'h5B;
  localparam logic [7:0] OFF_ADR2 = 8'h5C;
  localparam logic [7:0] OFF_CNTL = 8'h5D;
  localparam logic [7:0] OFF_CNTH = 8'h5E;
  localparam logic [7:0] OFF_IDLE = 8'h5F;
  // ********************************************
  // Field positions
  // ********************************************
  localparam int CMD_ACK = 7;
  localparam int CMD_RX_RESET_CMD = 6;
  localparam int CMD_XMS = 2;
  localparam int CMD_XME = 1;
  localparam int CMD_TX_RESET_CMD = 0;
  localparam int EV_RMR = 6;
  localparam int EV_RME = 5;
  localparam int EV_OVF = 4;
  localparam int EV_XFR = 1;
  localparam int EV_UND = 0;
  localparam int MODE_MMS = 7;
  // ********************************************
  // Reset values and fixed codes
  // ********************************************
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_MASK = 8'hFF;
  localparam logic [7:0] MASK_FIXED = 8'h8C;
  localparam logic RST_CRC = 1'h1;
  localparam logic [1:0] FTS_HI = 2'h2;
  localparam logic [7:0] THR_LO = 8'h40;
  localparam logic [7:0] THR_HI = 8'h60;

  // Threshold in bytes from the mode register
  function automatic logic [7:0] thr_of(input logic [7:0] mode);
    thr_of = (mode[1:0] == FTS_HI) ? THR_HI : THR_LO;
  endfunction
endpackage

// File: include/queue_if.sv
// Push and pop signals of one byte queue.
`timescale 1ns/1ps
interface queue_if;
  logic [7:0] wdata;
  logic wvalid;
  logic wready;
  logic [7:0] rdata;
  logic rvalid;
  logic rready;
  logic clr;
  logic [7:0] cnt;
  modport store (input wdata, wvalid, rready, clr,
                 output wready, rdata, rvalid, cnt);
  modport user (output wdata, wvalid, rready, clr,
                input wready, rdata, rvalid, cnt);
endinterface

// File: tb/line_model.sv
// Line-side partner: sends receive bytes and takes transmit bytes.
`timescale 1ns/1ps
module line_model (
  input wire logic clk_i,
  input wire logic stall_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  input wire logic rx_ready_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_end_o,
  output logic rx_crc_err_o,
  output logic rx_abort_o,
  output logic tx_ready_o,
  output logic tx_busy_o,
  output logic tx_underrun_o
);
  logic [7:0] taken_q[$];

  // Quiet line at time zero
  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    rx_end_o = 1'b0;
    rx_crc_err_o = 1'b0;
    rx_abort_o = 1'b0;
    tx_ready_o = 1'b0;
    tx_busy_o = 1'b0;
    tx_underrun_o = 1'b0;
  end

  // Back-to-back bytes; the last one may close the frame
  task automatic send(input int n, input logic [7:0] base,
                      input logic fin, input logic crc);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      rx_data_o <= base + 8'(i);
      rx_valid_o <= 1'b1;
      rx_end_o <= fin && (i == n - 1);
      rx_crc_err_o <= crc && (i == n - 1);
    end
    @(posedge clk_i);
    // Idle data is inverted so a stale byte is never mistaken for new
    rx_data_o <= ~(base + 8'(n - 1));
    rx_valid_o <= 1'b0;
    rx_end_o <= 1'b0;
    rx_crc_err_o <= 1'b0;
  endtask

  // One-cycle pulse of abort (und low) or underrun (und high)
  task automatic pulse(input logic und);
    @(posedge clk_i);
    rx_abort_o <= !und;
    tx_underrun_o <= und;
    @(posedge clk_i);
    rx_abort_o <= 1'b0;
    tx_underrun_o <= 1'b0;
  endtask

  task automatic set_busy(input logic b);
    @(posedge clk_i);
    tx_busy_o <= b;
  endtask

  // Takes a byte whenever valid meets ready; stall holds ready low
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      taken_q.push_back(tx_data_i);
    end
    tx_ready_o <= !stall_i;
  end
endmodule // line_model

// File: tb/tb_top.sv
// Self-checking bench of the B-channel host register block.
`timescale 1ns/1ps
module tb_top;
  import hdlc_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic stall = 1'b0;
  wire logic [7:0] rdata, rx_data, tx_data, mode_v, idle_v, am1, am2, ac1, ac2;
  wire logic rx_valid, rx_end, rx_crc, rx_abort, rx_ready, tx_valid;
  wire logic tx_ready, tx_busy, tx_und, tx_start, tx_end, tx_rst, rx_rst;
  int fails = 0;
  int total_checks = 0;
  int thr;
  logic [7:0] pulses [4] = '{default: 8'h00};
  logic [7:0] rw_off [5] = '{OFF_ADM1, OFF_ADM2, OFF_ADR1, OFF_ADR2, OFF_IDLE};

  always #4 clk = ~clk;

  bchan_regs dut (.SYS_CLK_I(clk), .SRST_I(srst), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .RX_DATA_I(rx_data), .RX_VALID_I(rx_valid), .RX_END_I(rx_end),
    .RX_CRC_ERR_I(rx_crc), .RX_ABORT_I(rx_abort), .RX_READY_O(rx_ready),
    .TX_DATA_O(tx_data), .TX_VALID_O(tx_valid), .TX_READY_I(tx_ready),
    .TX_BUSY_I(tx_busy), .TX_UNDERRUN_I(tx_und), .TX_START_O(tx_start),
    .TX_END_O(tx_end), .TX_RESET_O(tx_rst), .RX_RESET_O(rx_rst),
    .MODE_O(mode_v), .IDLE_O(idle_v), .ADDR_MASK1_O(am1),
    .ADDR_MASK2_O(am2), .ADDR_CMP1_O(ac1), .ADDR_CMP2_O(ac2));

  line_model line (.clk_i(clk), .stall_i(stall), .tx_data_i(tx_data),
    .tx_valid_i(tx_valid), .rx_ready_i(rx_ready), .rx_data_o(rx_data),
    .rx_valid_o(rx_valid), .rx_end_o(rx_end), .rx_crc_err_o(rx_crc),
    .rx_abort_o(rx_abort), .tx_ready_o(tx_ready), .tx_busy_o(tx_busy),
    .tx_underrun_o(tx_und));

  // Count command pulses: rx reset, start, end, tx reset
  always @(posedge clk) begin
    if (rx_rst === 1'b1) pulses[0] <= pulses[0] + 8'h01;
    if (tx_start === 1'b1) pulses[1] <= pulses[1] + 8'h01;
    if (tx_end === 1'b1) pulses[2] <= pulses[2] + 8'h01;
    if (tx_rst === 1'b1) pulses[3] <= pulses[3] + 8'h01;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t ns: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // One-cycle strobes; the idle cycle between calls keeps drivers clean
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd_reg(a, v);
    check(v, exp);
  endtask

  task automatic drain(input int n, input logic [7:0] base);
    logic [7:0] v;
    for (int i = 0; i < n; i++) begin
      rd_reg(OFF_RXQ, v);
      check(v, base + 8'(i));
    end
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Tests in order; each leaves the block idle for the next
  initial begin
    logic [7:0] v;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    expect_reg(OFF_CMD, 8'h00);
    expect_reg(OFF_MODE, RST_MODE);
    expect_reg(OFF_MASK, RST_MASK);
    expect_reg(OFF_STAT, 8'h20);
    expect_reg(OFF_EVT, 8'h00);
    wr_reg(OFF_MASK, 8'h00);
    expect_reg(OFF_MASK, MASK_FIXED);
    expect_reg(OFF_EVT, 8'h02);
    expect_reg(OFF_EVT, 8'h00);
    done("reset");
    wr_reg(8'h52, 8'h5A);
    wr_reg(8'h55, 8'h5A);
    wr_reg(OFF_CMD, 8'h38);
    expect_reg(8'h52, 8'h00);
    expect_reg(8'h55, 8'h00);
    expect_reg(OFF_TXQ, 8'h00);
    expect_reg(OFF_CMD, 8'h00);
    for (int i = 0; i < 5; i++) wr_reg(rw_off[i], 8'hA1 + 8'(i));
    for (int i = 0; i < 5; i++) expect_reg(rw_off[i], 8'hA1 + 8'(i));
    check(am1, 8'hA1);
    check(am2, 8'hA2);
    check(ac1, 8'hA3);
    check(ac2, 8'hA4);
    check(idle_v, 8'hA5);
    done("map");
    // Transmit events masked so only receive flags show
    wr_reg(OFF_MASK, 8'h03);
    for (int k = 0; k < 2; k++) begin
      thr = k ? 96 : 64;
      wr_reg(OFF_MODE, k ? 8'h02 : 8'h00);
      #1 check(mode_v, k ? 8'h02 : 8'h00);
      line.send(thr, 8'h10, 1'b0, 1'b0);
      expect_reg(OFF_EVT, 8'h00);
      line.send(1, 8'h10 + 8'(thr), 1'b0, 1'b0);
      expect_reg(OFF_EVT, 8'h40);
      drain(thr + 1, 8'h10);
      expect_reg(OFF_RXQ, 8'h00);
      wr_reg(OFF_CMD, 8'h80);
    end
    done("threshold");
    wr_reg(OFF_MODE, 8'h80);
    line.send(129, 8'h20, 1'b0, 1'b0);
    expect_reg(OFF_EVT, 8'h50);
    check({7'h00, rx_ready}, 8'h00);
    drain(128, 8'h20);
    check({7'h00, rx_ready}, 8'h01);
    line.pulse(1'b0);
    expect_reg(OFF_STAT, 8'h70);
    line.send(3, 8'h00, 1'b0, 1'b0);
    wr_reg(OFF_CMD, 8'h40);
    expect_reg(OFF_RXQ, 8'h00);
    expect_reg(OFF_STAT, 8'h20);
    check(pulses[0], 8'h01);
    wr_reg(OFF_CMD, 8'h80);
    done("overflow");
    wr_reg(OFF_MODE, 8'h00);
    line.send(10, 8'h30, 1'b1, 1'b0);
    expect_reg(OFF_EVT, 8'h20);
    expect_reg(OFF_STAT, 8'h00);
    expect_reg(OFF_CNTL, 8'h0A);
    expect_reg(OFF_CNTH, 8'h00);
    drain(10, 8'h30);
    wr_reg(OFF_CMD, 8'h80);
    line.send(3, 8'h40, 1'b1, 1'b1);
    expect_reg(OFF_EVT, 8'h20);
    expect_reg(OFF_STAT, 8'h20);
    expect_reg(OFF_CNTL, 8'h03);
    wr_reg(OFF_MODE, 8'h80);
    line.send(3, 8'h50, 1'b1, 1'b0);
    expect_reg(OFF_EVT, 8'h00);
    wr_reg(OFF_CMD, 8'h40);
    done("frame");
    wr_reg(OFF_MODE, 8'h00);
    wr_reg(OFF_MASK, 8'h00);
    expect_reg(OFF_EVT, 8'h00);
    stall <= 1'b1;
    for (int i = 0; i < 3; i++) wr_reg(OFF_TXQ, 8'h61 + 8'(i));
    wr_reg(OFF_CMD, 8'h04);
    wr_reg(OFF_CMD, 8'h02);
    stall <= 1'b0;
    repeat (20) @(posedge clk);
    check(8'(line.taken_q.size()), 8'h03);
    for (int i = 0; i < 3; i++) check(line.taken_q[i], 8'h61 + 8'(i));
    check(pulses[1], 8'h01);
    check(pulses[2], 8'h01);
    stall <= 1'b1;
    for (int i = 0; i < 130; i++) wr_reg(OFF_TXQ, 8'(i));
    rd_reg(OFF_STAT, v);
    check({7'h00, v[2]}, 8'h01);
    wr_reg(OFF_CMD, 8'h01);
    rd_reg(OFF_STAT, v);
    check({7'h00, v[2]}, 8'h00);
    expect_reg(OFF_EVT, 8'h02);
    check(pulses[3], 8'h01);
    stall <= 1'b0;
    repeat (20) @(posedge clk);
    check(8'(line.taken_q.size()), 8'h03);
    line.set_busy(1'b1);
    rd_reg(OFF_STAT, v);
    check({7'h00, v[0]}, 8'h01);
    line.pulse(1'b1);
    expect_reg(OFF_EVT, 8'h01);
    done("transmit");
    summarize();
  end

  // Whole sequence needs well under 20000 cycles
  initial begin
    #200000;
    fails++;
    $display("[ERR] %0t ns: watchdog expired", $time);
    summarize();
  end
endmodule // tb_top
